// *** verilog/map_top.sv ***
// Multichannel serial audio port: clock generation, lines, register port and FIFO
`timescale 1ns/10ps

// ==========================================================
// Receive FIFO
module map_fifo #(
  parameter int W = 28,
  parameter int D = 8
) (
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D+1)-1:0]    count
);
  localparam int PW = $clog2(D);
  logic [W-1:0]           mem_r [0:D-1];
  logic [PW-1:0]          wp_r;
  logic [PW-1:0]          rp_r;
  logic [$clog2(D+1)-1:0] cnt_r;
  logic                   push;
  logic                   pop;

  assign in_ready  = (cnt_r != D[$clog2(D+1)-1:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign count     = cnt_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(D - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end
endmodule // map_fifo

// ==========================================================
// Top
// Summary of operation
// (RULE_01) Eight output lines, two channels each
// (RULE_02) Eight input lines, two channels each
// (RULE_03) Common bit and word clocks driven out
// (RULE_04) Each input may follow external pair
// (RULE_05) External source rate not above ours
// (RULE_06) I2S or left justified, up to 24 bits
// (RULE_07) Exactly 64 bit clocks per frame
// (RULE_08) Master clock ratio 128 to 768
// (RULE_09) Dividers reach 48, 96, 192 kHz
// (RULE_10) Output data changes on falling edge
// (RULE_11) Input sampled on governing rising edge
// (RULE_12) Word select changes after rising edge
// (RULE_13) Format and ratio are software settings
// (RULE_14) I2S MSB one bit late, low left
// (RULE_15) Slots beyond width zero, ignored
module map_top #(
  parameter int LINES = map_pkg::LINES,
  parameter int SW    = map_pkg::SW
) (
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  input  wire logic [map_pkg::AW-1:0]  reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  output logic                         master_audio_clock_out,
  output logic                         audio_bit_clock_out,
  output logic                         audio_word_select_out,
  output logic      [LINES-1:0]        serial_audio_out_lines,
  input  wire logic [LINES-1:0]        serial_audio_in_lines,
  input  wire logic [1:0]              ext_bit_clock_in,
  input  wire logic [1:0]              ext_word_select_in
);
  import map_pkg::*;

  // ==========================================================
  // Registers
  logic             en_r;
  map_fmt_t         fmt_r;
  map_ratio_t       ratio_r;
  logic [4:0]       width_r;
  logic [7:0]       mdiv_r;
  logic [LINES-1:0] slv_en_r;
  logic [LINES-1:0] slv_sel_r;
  logic [SW-1:0]    hold_r [0:2*LINES-1];
  logic             ovr_r;
  logic [31:0]      rdata_r;
  logic [4:0]       wid_nxt;
  logic             fifo_pop;
  logic             fifo_ovalid;
  logic [FW-1:0]    fifo_odata;
  logic [3:0]       fifo_cnt;
  logic             tx_sel;
  logic [3:0]       tx_idx;

  assign tx_sel  = (reg_addr[7:6] == TX_PAGE);
  assign tx_idx  = reg_addr[5:2];
  assign wid_nxt = (reg_wdata[CTRL_WID_L +: 5] > WID_MAX) ? WID_MAX :
                   (reg_wdata[CTRL_WID_L +: 5] < WID_MIN) ? WID_MIN :
                   reg_wdata[CTRL_WID_L +: 5];
  assign fifo_pop = reg_rd && (reg_addr == OFS_RXDATA);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      en_r      <= 1'b0;
      fmt_r     <= FMT_I2S;
      ratio_r   <= R256;
      width_r   <= WID_RST;
      mdiv_r    <= MDIV_RST;
      slv_en_r  <= '0;
      slv_sel_r <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          en_r    <= reg_wdata[CTRL_EN];
          fmt_r   <= map_fmt_t'(reg_wdata[CTRL_FMT]); // RULE_13
          ratio_r <= map_ratio_t'(reg_wdata[CTRL_RAT_L +: 3]); // RULE_13
          width_r <= wid_nxt; // RULE_06
        end
        OFS_MDIV: mdiv_r <= reg_wdata[7:0];
        OFS_SLAVE: begin
          slv_en_r  <= reg_wdata[LINES-1:0]; // RULE_04
          slv_sel_r <= reg_wdata[LINES +: LINES]; // RULE_04
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reg_wr && tx_sel) begin
      hold_r[tx_idx] <= reg_wdata[SW-1:0];
    end
  end

  // ==========================================================
  // Clock generation
  logic [7:0] mcnt_r;
  logic       mclk_r;
  logic [3:0] hcnt_r;
  logic [3:0] half;
  logic       mtick;
  logic       bevt;
  logic       int_rise;
  logic       bclk_r;
  logic       ws_r;
  logic [5:0] bit_r;
  logic [5:0] bit_nxt;
  logic       ws_nxt;

  // Ratio of 128x and above with a fixed 64-clock frame sets the bit clock
  always_comb begin
    case (ratio_r)
      R128:    half = HALF_128; // RULE_08
      R256:    half = HALF_256;
      R512:    half = HALF_512;
      R192:    half = HALF_192;
      R384:    half = HALF_384;
      R768:    half = HALF_768;
      default: half = HALF_256;
    endcase
  end

  assign mtick    = en_r && (mcnt_r == mdiv_r); // RULE_09
  assign bevt     = mtick && (hcnt_r == half - 4'h1);
  assign int_rise = bevt && !bclk_r;
  assign bit_nxt  = bit_r + 6'h01; // RULE_07
  assign ws_nxt   = bit_nxt[5];

  always_ff @(posedge ref_clk) begin
    if (!nrst || !en_r) begin
      mcnt_r <= '0;
      mclk_r <= 1'b0;
      hcnt_r <= '0;
    end else begin
      mcnt_r <= mtick ? 8'h00 : mcnt_r + 8'h01;
      if (mtick) begin
        mclk_r <= !mclk_r; // RULE_03
        hcnt_r <= bevt ? 4'h0 : hcnt_r + 4'h1;
      end
    end
  end

  // Word select moves only on the rising event, ahead of the next falling edge
  always_ff @(posedge ref_clk) begin
    if (!nrst || !en_r) begin
      bclk_r <= 1'b0;
      ws_r   <= 1'b0;
    end else if (bevt) begin
      bclk_r <= !bclk_r; // RULE_03
      if (!bclk_r) begin
        ws_r <= ws_nxt; // RULE_12 RULE_14
      end
    end
  end

  // ==========================================================
  // Transmit lines
  logic [4:0] tx_pos;

  assign tx_pos = bit_nxt[4:0] - ((fmt_r == FMT_I2S) ? 5'h01 : 5'h00); // RULE_14

  always_ff @(posedge ref_clk) begin
    if (!nrst || !en_r) begin
      bit_r <= BITS_LAST;
    end else if (bevt && bclk_r) begin
      bit_r <= bit_nxt; // RULE_07 RULE_10
    end
  end

  for (genvar l = 0; l < LINES; l++) begin : g_tx
    logic [SW-1:0] word;
    logic [4:0]    bsel;
    assign word = hold_r[2*l + (bit_nxt[5] ? 1 : 0)]; // RULE_01
    assign bsel = width_r - 5'h01 - tx_pos;
    always_ff @(posedge ref_clk) begin
      if (!nrst || !en_r) begin
        serial_audio_out_lines[l] <= 1'b0;
      end else if (bevt && bclk_r) begin
        serial_audio_out_lines[l] <= (tx_pos < width_r) ? word[bsel] : 1'b0; // RULE_10 RULE_15
      end
    end
  end

  // ==========================================================
  // Receive lines
  logic [1:0]       xb_q;
  logic [1:0]       xrise;
  logic [LINES-1:0] pend_r;
  logic [LINES-1:0] done;
  logic [LINES-1:0] clr;
  logic [SW:0]      cap_r [0:LINES-1];
  logic [2:0]       ptr_r;
  logic             fifo_ready;
  logic [5:0]       rx_cnt0_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      xb_q <= '0;
    end else begin
      xb_q <= ext_bit_clock_in;
    end
  end
  assign xrise = ext_bit_clock_in & ~xb_q;

  for (genvar l = 0; l < LINES; l++) begin : g_rx
    logic          rise;
    logic          wsi;
    logic          din;
    logic          wsp_r;
    logic [5:0]    cnt_r;
    logic [5:0]    pos;
    logic [SW-1:0] sh_r;
    // External pair must run no faster than the internal frame rate
    assign rise = slv_en_r[l] ? xrise[slv_sel_r[l]] : int_rise; // RULE_04 RULE_05
    assign wsi  = slv_en_r[l] ? ext_word_select_in[slv_sel_r[l]] : ws_r;
    assign din  = serial_audio_in_lines[l];
    assign pos  = cnt_r - ((fmt_r == FMT_I2S) ? 6'h01 : 6'h00); // RULE_14
    assign done[l] = rise && (wsi != wsp_r);
    always_ff @(posedge ref_clk) begin
      if (!nrst || !en_r) begin
        wsp_r <= 1'b0;
        cnt_r <= '0;
        sh_r  <= '0;
      end else if (rise) begin // RULE_11
        if (wsi != wsp_r) begin
          wsp_r <= wsi;
          cnt_r <= 6'h01;
          sh_r  <= (fmt_r == FMT_LJ) ? SW'(din) : '0; // RULE_14
        end else begin
          cnt_r <= (cnt_r == BITS_LAST) ? cnt_r : cnt_r + 6'h01;
          if (pos < {1'b0, width_r}) begin
            sh_r <= {sh_r[SW-2:0], din}; // RULE_02 RULE_15
          end
        end
      end
    end
    always_ff @(posedge ref_clk) begin
      if (done[l]) begin
        cap_r[l] <= {wsp_r, sh_r};
      end
    end
    // A new sample wins over the scanner draining the old one
    always_ff @(posedge ref_clk) begin
      if (!nrst) begin
        pend_r[l] <= 1'b0;
      end else begin
        pend_r[l] <= done[l] || (pend_r[l] && !clr[l]);
      end
    end
    assign clr[l] = fifo_ready && (ptr_r == 3'(l));
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rx_cnt0_q <= '0;
    end else begin
      rx_cnt0_q <= g_rx[0].cnt_r;
    end
  end

  // Scanner stalls while the FIFO is full, so loss shows as overrun
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ptr_r <= '0;
    end else if (!pend_r[ptr_r] || fifo_ready) begin
      ptr_r <= ptr_r + 3'h1;
    end
  end

  map_fifo #(.W(FW), .D(FDEP)) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (pend_r[ptr_r]),
    .in_ready  (fifo_ready),
    .in_data   ({ptr_r, cap_r[ptr_r]}),
    .out_valid (fifo_ovalid),
    .out_ready (fifo_pop),
    .out_data  (fifo_odata),
    .count     (fifo_cnt)
  );

  // Overrun set wins over software clear
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ovr_r <= 1'b0;
    end else if (|(done & pend_r & ~clr)) begin
      ovr_r <= 1'b1;
    end else if (reg_wr && reg_addr == OFS_STAT && reg_wdata[STAT_OVR]) begin
      ovr_r <= 1'b0;
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= '0;
      if (tx_sel) begin
        rdata_r[SW-1:0] <= hold_r[tx_idx];
      end else begin
        case (reg_addr)
          OFS_CTRL: begin
            rdata_r[CTRL_EN]           <= en_r;
            rdata_r[CTRL_FMT]          <= fmt_r;
            rdata_r[CTRL_RAT_L +: 3]   <= ratio_r;
            rdata_r[CTRL_WID_L +: 5]   <= width_r;
          end
          OFS_MDIV:  rdata_r[7:0] <= mdiv_r;
          OFS_SLAVE: rdata_r[2*LINES-1:0] <= {slv_sel_r, slv_en_r};
          OFS_STAT: begin
            rdata_r[STAT_OVR]        <= ovr_r;
            rdata_r[STAT_CNT_L +: 4] <= fifo_cnt;
            rdata_r[STAT_BIT_L +: 6] <= bit_r;
          end
          OFS_RXDATA: begin
            rdata_r[RX_VALID] <= fifo_ovalid;
            rdata_r[FW-1:0]   <= fifo_ovalid ? fifo_odata : '0;
          end
          default: ;
        endcase
      end
    end
  end

  assign reg_rdata              = rdata_r;
  assign master_audio_clock_out = mclk_r;
  assign audio_bit_clock_out    = bclk_r;
  assign audio_word_select_out  = ws_r;

  // ==========================================================
  // Checks
  logic [6:0] fc_r;
  logic       fseen_r;
  always_ff @(posedge ref_clk) begin
    if (!nrst || !en_r) begin
      fc_r    <= '0;
      fseen_r <= 1'b0;
    end else if (int_rise) begin
      fc_r    <= (!ws_r && ws_nxt) ? 7'h01 : fc_r + 7'h01;
      fseen_r <= fseen_r || (!ws_r && ws_nxt);
    end
  end

  ws_after_rise_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_12
    $changed(ws_r) |-> $rose(bclk_r))
    else $error("word select moved away from a rising bit clock");
  data_on_fall_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_10
    $changed(serial_audio_out_lines) |-> $fell(bclk_r))
    else $error("output data moved away from a falling bit clock");
  frame_len_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_07
    (int_rise && !ws_r && ws_nxt && fseen_r) |-> fc_r == FRAME_LEN)
    else $error("frame is not 64 bit clocks");
  pad_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_15
    (bevt && bclk_r && tx_pos >= width_r) |=> serial_audio_out_lines == '0)
    else $error("pad slot not zero");
  i2s_delay_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_14
    (bevt && bclk_r && fmt_r == FMT_I2S && bit_nxt[4:0] == 5'h00)
      |=> serial_audio_out_lines == '0)
    else $error("I2S slot start is not the delay bit");
  rx_on_rise_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_11
    (en_r && $past(en_r) && rx_cnt0_q != g_rx[0].cnt_r) |-> $past(g_rx[0].rise))
    else $error("input line advanced without its rising edge");
  cfg_write_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_13
    (reg_wr && reg_addr == OFS_CTRL) |=> ratio_r == $past(reg_wdata[CTRL_RAT_L +: 3]))
    else $error("ratio setting not taken");
  slave_mux_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_04
    (en_r && slv_en_r[0] && !xrise[slv_sel_r[0]]) |=> $stable(g_rx[0].cnt_r))
    else $error("slaved line advanced without its external bit clock");
  mclk_step_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE_03
    $changed(bclk_r) |-> $changed(mclk_r))
    else $error("bit clock not aligned to master clock");
endmodule // map_top

// *** verilog/map_pkg.sv ***
// Constants, field layout and modes of the multichannel serial audio port
package map_pkg;
  // ==========================================================
  // Geometry
  localparam int LINES = 8;
  localparam int SW    = 24;
  localparam int AW    = 8;
  localparam int FW    = 28;
  localparam int FDEP  = 8;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MDIV   = 8'h04;
  localparam logic [7:0] OFS_SLAVE  = 8'h08;
  localparam logic [7:0] OFS_STAT   = 8'h0C;
  localparam logic [7:0] OFS_RXDATA = 8'h10;
  localparam logic [1:0] TX_PAGE    = 2'h1;

  // ==========================================================
  // Fields and reset values
  localparam int CTRL_EN    = 0;
  localparam int CTRL_FMT   = 1;
  localparam int CTRL_RAT_L = 2;
  localparam int CTRL_WID_L = 8;
  localparam int STAT_OVR   = 0;
  localparam int STAT_CNT_L = 4;
  localparam int STAT_BIT_L = 16;
  localparam int RX_VALID   = 31;
  localparam logic [4:0] WID_MAX   = 5'h18;
  localparam logic [4:0] WID_MIN   = 5'h01;
  localparam logic [4:0] WID_RST   = 5'h18;
  localparam logic [7:0] MDIV_RST  = 8'h00;
  localparam logic [5:0] BITS_LAST = 6'h3F;
  localparam logic [6:0] FRAME_LEN = 7'h40;

  // ==========================================================
  // Modes
  typedef enum logic {FMT_I2S = 1'b0, FMT_LJ = 1'b1} map_fmt_t;
  typedef enum logic [2:0] {
    R128 = 3'b000, R256 = 3'b001, R512 = 3'b010,
    R192 = 3'b011, R384 = 3'b100, R768 = 3'b101
  } map_ratio_t;

  // Bit clock half period counted in master clock half periods
  localparam logic [3:0] HALF_128 = 4'h2;
  localparam logic [3:0] HALF_256 = 4'h4;
  localparam logic [3:0] HALF_512 = 4'h8;
  localparam logic [3:0] HALF_192 = 4'h3;
  localparam logic [3:0] HALF_384 = 4'h6;
  localparam logic [3:0] HALF_768 = 4'hC;
endpackage

// *** tb/map_codec_model.sv ***
// Far-side converter model: loops serial data back and echoes the clocks on both external pairs
`timescale 1ns/10ps

// ==========================================================
// Converter model
module map_codec_model (
  input  wire logic       ref_clk,
  input  wire logic       bclk,
  input  wire logic       ws,
  input  wire logic [7:0] out_lines,
  output logic      [7:0] in_lines = 8'h00,
  output logic      [1:0] ext_bclk = 2'h0,
  output logic      [1:0] ext_ws   = 2'h0
);
  logic ws_d = 1'b0;

  // Echo of our own clocks keeps the external rate equal to the internal one
  // Word select trails the echoed bit clock by a cycle, so it moves after the rise
  always @(posedge ref_clk) begin
    ws_d     <= ws;
    ext_bclk <= {2{bclk}};
    ext_ws   <= {2{ws_d}};
  end

  // One cycle of converter delay, well inside half a bit period
  always @(posedge ref_clk) begin
    in_lines <= out_lines;
  end
endmodule // map_codec_model

// *** tb/testbench.sv ***
// Self-checking bench for the multichannel serial audio port
`timescale 1ns/10ps

// ==========================================================
// Bench
module testbench;
  import map_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} map_row_t;
  logic        ref_clk   = 1'b0;
  logic        nrst      = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata;
  logic        mclk;
  logic        bclk;
  logic        ws;
  logic [7:0]  out_lines;
  logic [7:0]  in_lines;
  logic [1:0]  ext_bclk;
  logic [1:0]  ext_ws;
  logic        mon_on    = 1'b0;
  logic        bclk_q    = 1'b0;
  logic        ws_q      = 1'b0;
  logic [7:0]  out_q     = 8'h00;
  int          rises     = -1000;
  int          cyc       = 0;
  int          mismatches = 0;
  int          n_checks  = 0;
  logic [3:0]  halves [6] = '{HALF_128, HALF_256, HALF_512, HALF_192, HALF_384, HALF_768};
  map_row_t    rows [7] = '{
    '{OFS_MDIV,  32'h0000005A, 32'h0000005A},
    '{OFS_SLAVE, 32'h0000A5C3, 32'h0000A5C3},
    '{8'h40,     32'hFFFFFFFF, 32'h00FFFFFF},
    '{8'h7C,     32'h00123456, 32'h00123456},
    '{8'h20,     32'h12345678, 32'h00000000},
    '{OFS_CTRL,  32'h00001F08, 32'h00001808},
    '{OFS_CTRL,  32'h00000016, 32'h00000116}
  };

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  map_top dut (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .master_audio_clock_out(mclk), .audio_bit_clock_out(bclk),
    .audio_word_select_out(ws), .serial_audio_out_lines(out_lines),
    .serial_audio_in_lines(in_lines), .ext_bit_clock_in(ext_bclk),
    .ext_word_select_in(ext_ws)
  );

  map_codec_model partner (
    .ref_clk(ref_clk), .bclk(bclk), .ws(ws), .out_lines(out_lines),
    .in_lines(in_lines), .ext_bclk(ext_bclk), .ext_ws(ext_ws)
  );

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  function automatic logic [23:0] txv(input logic [3:0] i);
    return 24'hABCDEF ^ ({20'h00000, i} * 24'h010203);
  endfunction

  // Four bits of line 0 at bit clock rises, starting after the left word begins
  task automatic wire_bits(input int skip, input logic [3:0] exp);
    logic [3:0] got;
    @(negedge ws);
    // Step off the edge that moved word select, so its own bit clock rise is not counted
    @(negedge ref_clk);
    repeat (skip) @(posedge bclk);
    for (int k = 3; k >= 0; k--) begin
      @(posedge bclk);
      got[k] = out_lines[0];
    end
    chk({28'h0, got}, {28'h0, exp});
  endtask

  // Stale words are drained first, since a full FIFO holds samples from older settings
  task automatic loop_pass(input logic [23:0] mask);
    logic [31:0] w;
    repeat (800) @(posedge ref_clk);
    rd(OFS_STAT, w);
    chk({31'h0, w[STAT_OVR]}, 32'h1);
    repeat (24) rd(OFS_RXDATA, w);
    repeat (300) @(posedge ref_clk);
    repeat (8) begin
      rd(OFS_RXDATA, w);
      chk({31'h0, w[RX_VALID]}, 32'h1);
      chk({8'h0, w[23:0]}, {8'h0, txv({w[27:25], w[24]}) & mask});
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // Wire monitor, sampled mid-cycle where all outputs have settled
  always @(negedge ref_clk) begin
    if (mon_on) begin
      if (out_lines !== out_q) chk({31'h0, bclk_q & ~bclk}, 32'h1);
      if (ws !== ws_q) chk({31'h0, bclk}, 32'h1);
      if (bclk && !bclk_q) rises++;
      if (ws && !ws_q) begin
        if (rises >= 0) chk(rises, 64);
        rises = 0;
      end
    end
    bclk_q = bclk;
    ws_q   = ws;
    out_q  = out_lines;
  end

  initial begin
    #(40 * 60000);
    mismatches++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] v;
    int          t0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk({28'h0, mclk, bclk, ws, |out_lines}, 32'h0);
    rd(OFS_CTRL, v);
    chk(v, 32'h00001804);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    for (int i = 0; i < 16; i++) wr(8'(32'h40 + 4 * i), {8'h00, txv(4'(i))});
    wr(OFS_MDIV, 32'h0);
    wr(OFS_SLAVE, 32'h0);
    wr(OFS_CTRL, {19'h0, WID_MAX, 3'h0, R128, FMT_I2S, 1'b1});
    mon_on = 1'b1;
    wire_bits(1, 4'hA);
    loop_pass(24'hFFFFFF);
    // Lines 0 and 1 follow the external pairs, line 1 on pair 1
    mon_on = 1'b0;
    wr(OFS_SLAVE, 32'h00000203);
    wr(OFS_CTRL, {19'h0, 5'h10, 3'h0, R128, FMT_LJ, 1'b1});
    rises = -1000;
    mon_on = 1'b1;
    wire_bits(0, 4'hC);
    loop_pass(24'h00FFFF);
    mon_on = 1'b0;
    wr(OFS_SLAVE, 32'h0);
    wr(OFS_MDIV, 32'h1);
    @(posedge mclk);
    #1;
    t0 = cyc;
    @(posedge mclk);
    #1;
    chk(cyc - t0, 4);
    for (int r = 0; r < 6; r++) begin
      wr(OFS_CTRL, {19'h0, WID_MAX, 3'h0, 3'(r), FMT_I2S, 1'b1});
      repeat (2) @(posedge bclk);
      #1;
      t0 = cyc;
      @(posedge bclk);
      #1;
      chk(cyc - t0, 4 * int'(halves[r]));
    end
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk({28'h0, mclk, bclk, ws, |out_lines}, 32'h0);
    rd(OFS_CTRL, v);
    chk(v, 32'h00001804);
    conclude();
  end
endmodule // testbench
